// File: common/ssd_defines.vh
// constants for the supervisor special register decode block
// assumes 32-bit instruction words in little-endian bit numbering (bit 31 = msb)
// Summary of operation
// - spr number rebuilt from swapped five-bit halves
// - 952 and 956 select monitor control registers
// - 953,954,957,958 select counters one to four
// - 955 sampled instruction, 959 sampled data address
// - 1010 selects instruction breakpoint address register
// - 1023 selects processor identification register
// - state register moves to and from general registers
// - spr moves reach supervisor and user registers
// - invalidate computes, translates, protection-checks address first
// - invalidate issues a bus kill unless translation faults or the segment is direct-store
// - present block invalidated, modified data discarded
// - invalidate supervisor only, checked as store
// - direct-store segment makes cache instruction a no-op
// - segment moves ignore relocation bits
// - segment moves direct and indirect forms
`ifndef SSD_DEFINES_VH
`define SSD_DEFINES_VH

// ---------------------------------------------------------------
// instruction fields
// ---------------------------------------------------------------
`define SSD_PRIMARY_OP       6'h1f
`define SSD_XO_MFMSR         10'h053
`define SSD_XO_MTMSR         10'h092
`define SSD_XO_MFSPR         10'h153
`define SSD_XO_MTSPR         10'h1d3
`define SSD_XO_DCBI          10'h1d6
`define SSD_XO_MFSR          10'h253
`define SSD_XO_MFSRIN        10'h293
`define SSD_XO_MTSR          10'h0d2
`define SSD_XO_MTSRIN        10'h0f2

// ---------------------------------------------------------------
// special register numbers
// ---------------------------------------------------------------
`define SSD_SPR_MON_CTRL0    10'h3b8
`define SSD_SPR_COUNT1       10'h3b9
`define SSD_SPR_COUNT2       10'h3ba
`define SSD_SPR_SAMP_IADDR   10'h3bb
`define SSD_SPR_MON_CTRL1    10'h3bc
`define SSD_SPR_COUNT3       10'h3bd
`define SSD_SPR_COUNT4       10'h3be
`define SSD_SPR_SAMP_DADDR   10'h3bf
`define SSD_SPR_IBRK_ADDR    10'h3f2
`define SSD_SPR_PROC_ID      10'h3ff
`define SSD_SPR_NUM_LOCAL    10
`define SSD_SPR_PRIV_BIT     4

// ---------------------------------------------------------------
// state register and reset values
// ---------------------------------------------------------------
`define SSD_MSR_PROBLEM_BIT  14
`define SSD_MSR_RESET        32'h00000000
`define SSD_SPR_RESET        32'h00000000
`define SSD_SR_IDX_MSB       31
`define SSD_SR_IDX_LSB       28

`endif

// File: design/ssd_reg32.v
// one software-visible special register held in flip-flops
// assumes write enable is a single-cycle strobe in the core clock domain
`timescale 1ns/100ps
module ssd_reg32 #(
   parameter                WIDTH = 32,
   parameter [WIDTH-1:0]    RESET = {WIDTH{1'b0}}
) (
   // clock and reset
   input  wire              i_clk,
   input  wire              i_rst_n,
   // write port
   input  wire              i_we,
   input  wire [WIDTH-1:0]  i_d,
   // value
   output wire [WIDTH-1:0]  o_q
);
   reg [WIDTH-1:0] value_q;

   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         value_q <= RESET;
      end else if (i_we) begin
         value_q <= i_d;
      end
   end

   assign o_q = value_q;
endmodule // ssd_reg32

// File: design/ssd_sprnum.v
// special register number rebuild and local register select
// assumes a 32-bit instruction word, combinational only
`timescale 1ns/100ps
`include "ssd_defines.vh"
module ssd_sprnum (
   // instruction
   input  wire [31:0] i_instr,
   // decoded number
   output wire [9:0]  o_spr_num,
   output reg  [9:0]  o_hit,
   output wire        o_local,
   output wire        o_priv
);
   // high half sits in the lower instruction field
   assign o_spr_num = {i_instr[15:11], i_instr[20:16]};

   always @* begin
      o_hit    = 10'h000;
      o_hit[0] = (o_spr_num == `SSD_SPR_MON_CTRL0);
      o_hit[1] = (o_spr_num == `SSD_SPR_COUNT1);
      o_hit[2] = (o_spr_num == `SSD_SPR_COUNT2);
      o_hit[3] = (o_spr_num == `SSD_SPR_SAMP_IADDR);
      o_hit[4] = (o_spr_num == `SSD_SPR_MON_CTRL1);
      o_hit[5] = (o_spr_num == `SSD_SPR_COUNT3);
      o_hit[6] = (o_spr_num == `SSD_SPR_COUNT4);
      o_hit[7] = (o_spr_num == `SSD_SPR_SAMP_DADDR);
      o_hit[8] = (o_spr_num == `SSD_SPR_IBRK_ADDR);
      o_hit[9] = (o_spr_num == `SSD_SPR_PROC_ID);
   end

   assign o_local = |o_hit;
   // supervisor registers carry this bit of the number
   assign o_priv  = o_spr_num[`SSD_SPR_PRIV_BIT];
endmodule // ssd_sprnum

// File: design/ssd_decode.v
// supervisor instruction decode: state register, special registers,
// block invalidate with bus kill, segment register moves
// assumes issue, translation, cache, bus and segment ports share i_clk
`timescale 1ns/100ps
`include "ssd_defines.vh"
module ssd_decode (
   // clock and reset
   input  wire        i_clk,
   input  wire        i_rst_n,
   // issue
   input  wire        i_valid,
   input  wire [31:0] i_instr,
   input  wire [31:0] i_ra_val,
   input  wire [31:0] i_rb_val,
   input  wire [31:0] i_rs_val,
   output wire        o_ready,
   // completion
   output reg         o_done,
   output reg         o_rd_we,
   output reg  [31:0] o_rd_data,
   output reg         o_priv_fault,
   output reg         o_access_fault,
   output reg         o_illegal,
   // state register
   output wire [31:0] o_msr,
   // translation
   output reg         o_xlat_req,
   output reg  [31:0] o_xlat_ea,
   output wire        o_xlat_store,
   input  wire        i_xlat_ack,
   input  wire        i_xlat_fault,
   input  wire        i_xlat_direct_store,
   input  wire [31:0] i_xlat_pa,
   // data cache
   output reg         o_dc_inval_req,
   output reg  [31:0] o_dc_inval_addr,
   input  wire        i_dc_inval_ack,
   // system bus
   output reg         o_bus_kill_req,
   output reg  [31:0] o_bus_kill_addr,
   input  wire        i_bus_kill_ack,
   // segment registers
   output reg         o_sr_we,
   output reg         o_sr_rd_req,
   output reg  [3:0]  o_sr_idx,
   output reg  [31:0] o_sr_wdata,
   input  wire [31:0] i_sr_rdata,
   // other special registers
   output reg         o_xspr_req,
   output reg         o_xspr_write,
   output reg  [9:0]  o_xspr_num,
   output reg  [31:0] o_xspr_wdata,
   input  wire        i_xspr_ack,
   input  wire [31:0] i_xspr_rdata
);
   // ---------------------------------------------------------------
   // states
   // ---------------------------------------------------------------
   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_XLAT = 3'h1;
   localparam [2:0] ST_KILL = 3'h2;
   localparam [2:0] ST_XSPR = 3'h3;
   localparam [2:0] ST_SRRD = 3'h4;

   reg  [2:0]  state_q;
   reg  [31:0] msr_q;
   reg         dc_seen_q;
   reg         bus_seen_q;

   // ---------------------------------------------------------------
   // decode
   // ---------------------------------------------------------------
   wire [9:0]  xo       = i_instr[10:1];
   wire        prim_ok  = (i_instr[31:26] == `SSD_PRIMARY_OP);
   wire        is_mfmsr = prim_ok && (xo == `SSD_XO_MFMSR);
   wire        is_mtmsr = prim_ok && (xo == `SSD_XO_MTMSR);
   wire        is_mfspr = prim_ok && (xo == `SSD_XO_MFSPR);
   wire        is_mtspr = prim_ok && (xo == `SSD_XO_MTSPR);
   wire        is_dcbi  = prim_ok && (xo == `SSD_XO_DCBI);
   wire        is_mfsr  = prim_ok && (xo == `SSD_XO_MFSR);
   wire        is_mfsri = prim_ok && (xo == `SSD_XO_MFSRIN);
   wire        is_mtsr  = prim_ok && (xo == `SSD_XO_MTSR);
   wire        is_mtsri = prim_ok && (xo == `SSD_XO_MTSRIN);
   wire        is_sr_rd = is_mfsr | is_mfsri;
   wire        is_sr_wr = is_mtsr | is_mtsri;
   wire        is_spr   = is_mfspr | is_mtspr;
   wire        known    = is_mfmsr | is_mtmsr | is_spr | is_dcbi | is_sr_rd | is_sr_wr;
   // problem-state bit clear means supervisor
   wire        in_super = ~msr_q[`SSD_MSR_PROBLEM_BIT];
   wire        take     = i_valid && (state_q == ST_IDLE);

   wire [9:0]  spr_num;
   wire [9:0]  spr_hit;
   wire        spr_local;
   wire        spr_priv;

   ssd_sprnum ssd_sprnum_inst (
      .i_instr   (i_instr),
      .o_spr_num (spr_num),
      .o_hit     (spr_hit),
      .o_local   (spr_local),
      .o_priv    (spr_priv)
   );

   // every move here except user-level spr is supervisor only
   wire need_super = is_mfmsr | is_mtmsr | is_dcbi | is_sr_rd | is_sr_wr | (is_spr & spr_priv);
   wire priv_bad   = need_super & ~in_super;
   wire go         = take & known & ~priv_bad;

   // direct field or top operand bits; relocation bits never consulted
   wire [3:0]  sr_index = (is_mtsri | is_mfsri) ? i_rb_val[`SSD_SR_IDX_MSB:`SSD_SR_IDX_LSB]
                                                : i_instr[19:16];

   // ra field of zero means a literal zero base
   wire [31:0] ea_base = (i_instr[20:16] == 5'h00) ? 32'h00000000 : i_ra_val;
   wire [31:0] ea_sum  = ea_base + i_rb_val;

   // ---------------------------------------------------------------
   // implementation special registers
   // ---------------------------------------------------------------
   wire [31:0] spr_q [0:`SSD_SPR_NUM_LOCAL-1];
   wire        spr_wr = go & is_mtspr & spr_local;

   genvar g;
   generate
      for (g = 0; g < `SSD_SPR_NUM_LOCAL; g = g + 1) begin : g_spr
         ssd_reg32 #(
            .WIDTH (32),
            .RESET (`SSD_SPR_RESET)
         ) ssd_reg32_inst (
            .i_clk   (i_clk),
            .i_rst_n (i_rst_n),
            .i_we    (spr_wr & spr_hit[g]),
            .i_d     (i_rs_val),
            .o_q     (spr_q[g])
         );
      end
   endgenerate

   reg [31:0] spr_rdata;
   integer    k;
   always @* begin
      spr_rdata = 32'h00000000;
      for (k = 0; k < `SSD_SPR_NUM_LOCAL; k = k + 1) begin
         if (spr_hit[k]) begin
            spr_rdata = spr_q[k];
         end
      end
   end

   // ---------------------------------------------------------------
   // sequencing
   // ---------------------------------------------------------------
   assign o_ready      = (state_q == ST_IDLE);
   assign o_msr        = msr_q;
   // invalidate destroys data, so it is checked as a store
   assign o_xlat_store = 1'b1;

   wire dc_done  = dc_seen_q | i_dc_inval_ack;
   wire bus_done = bus_seen_q | i_bus_kill_ack;

   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_q         <= ST_IDLE;
         msr_q           <= `SSD_MSR_RESET;
         dc_seen_q       <= 1'b0;
         bus_seen_q      <= 1'b0;
         o_done          <= 1'b0;
         o_rd_we         <= 1'b0;
         o_rd_data       <= 32'h00000000;
         o_priv_fault    <= 1'b0;
         o_access_fault  <= 1'b0;
         o_illegal       <= 1'b0;
         o_xlat_req      <= 1'b0;
         o_xlat_ea       <= 32'h00000000;
         o_dc_inval_req  <= 1'b0;
         o_dc_inval_addr <= 32'h00000000;
         o_bus_kill_req  <= 1'b0;
         o_bus_kill_addr <= 32'h00000000;
         o_sr_we         <= 1'b0;
         o_sr_rd_req     <= 1'b0;
         o_sr_idx        <= 4'h0;
         o_sr_wdata      <= 32'h00000000;
         o_xspr_req      <= 1'b0;
         o_xspr_write    <= 1'b0;
         o_xspr_num      <= 10'h000;
         o_xspr_wdata    <= 32'h00000000;
      end else begin
         // completion and strobes are one-cycle pulses
         o_done         <= 1'b0;
         o_rd_we        <= 1'b0;
         o_priv_fault   <= 1'b0;
         o_access_fault <= 1'b0;
         o_illegal      <= 1'b0;
         o_sr_we        <= 1'b0;
         o_sr_rd_req    <= 1'b0;
         case (state_q)
            ST_IDLE: begin
               if (take) begin
                  if (!known) begin
                     o_done    <= 1'b1;
                     o_illegal <= 1'b1;
                  end else if (priv_bad) begin
                     o_done       <= 1'b1;
                     o_priv_fault <= 1'b1;
                  end else if (is_mfmsr) begin
                     o_done    <= 1'b1;
                     o_rd_we   <= 1'b1;
                     o_rd_data <= msr_q;
                  end else if (is_mtmsr) begin
                     o_done <= 1'b1;
                     msr_q  <= i_rs_val;
                  end else if (is_spr && spr_local) begin
                     o_done    <= 1'b1;
                     o_rd_we   <= is_mfspr;
                     o_rd_data <= is_mfspr ? spr_rdata : o_rd_data;
                  end else if (is_spr) begin
                     // standard registers live elsewhere in the core
                     o_xspr_req   <= 1'b1;
                     o_xspr_write <= is_mtspr;
                     o_xspr_num   <= spr_num;
                     o_xspr_wdata <= i_rs_val;
                     state_q      <= ST_XSPR;
                  end else if (is_dcbi) begin
                     o_xlat_req <= 1'b1;
                     o_xlat_ea  <= ea_sum;
                     state_q    <= ST_XLAT;
                  end else if (is_sr_wr) begin
                     o_done     <= 1'b1;
                     o_sr_we    <= 1'b1;
                     o_sr_idx   <= sr_index;
                     o_sr_wdata <= i_rs_val;
                  end else begin
                     o_sr_rd_req <= 1'b1;
                     o_sr_idx    <= sr_index;
                     state_q     <= ST_SRRD;
                  end
               end
            end
            ST_XLAT: begin
               if (i_xlat_ack) begin
                  o_xlat_req <= 1'b0;
                  if (i_xlat_fault) begin
                     o_done         <= 1'b1;
                     o_access_fault <= 1'b1;
                     state_q        <= ST_IDLE;
                  end else if (i_xlat_direct_store) begin
                     // no cache or bus traffic at all
                     o_done  <= 1'b1;
                     state_q <= ST_IDLE;
                  end else begin
                     // cache drops the line in any state, no write-back
                     o_dc_inval_req  <= 1'b1;
                     o_dc_inval_addr <= i_xlat_pa;
                     // kill goes out whether or not the line hits
                     o_bus_kill_req  <= 1'b1;
                     o_bus_kill_addr <= i_xlat_pa;
                     dc_seen_q       <= 1'b0;
                     bus_seen_q      <= 1'b0;
                     state_q         <= ST_KILL;
                  end
               end
            end
            ST_KILL: begin
               if (i_dc_inval_ack) begin
                  o_dc_inval_req <= 1'b0;
                  dc_seen_q      <= 1'b1;
               end
               if (i_bus_kill_ack) begin
                  o_bus_kill_req <= 1'b0;
                  bus_seen_q     <= 1'b1;
               end
               if (dc_done && bus_done) begin
                  o_done     <= 1'b1;
                  dc_seen_q  <= 1'b0;
                  bus_seen_q <= 1'b0;
                  state_q    <= ST_IDLE;
               end
            end
            ST_XSPR: begin
               if (i_xspr_ack) begin
                  o_xspr_req <= 1'b0;
                  o_done     <= 1'b1;
                  o_rd_we    <= ~o_xspr_write;
                  o_rd_data  <= o_xspr_write ? o_rd_data : i_xspr_rdata;
                  state_q    <= ST_IDLE;
               end
            end
            ST_SRRD: begin
               // segment data is valid in the same cycle as the read strobe
               o_done    <= 1'b1;
               o_rd_we   <= 1'b1;
               o_rd_data <= i_sr_rdata;
               state_q   <= ST_IDLE;
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end
endmodule // ssd_decode

// File: bench/ssd_chk.sv
// concurrent checks on the supervisor decode block ports
// assumes one core clock and bind onto every ssd_decode
`timescale 1ns/100ps
`include "ssd_defines.vh"
module ssd_chk (
   // clock and reset
   input wire        i_clk,
   input wire        i_rst_n,
   // watched ports
   input wire        i_valid,
   input wire [31:0] i_instr,
   input wire [31:0] i_rb_val,
   input wire        o_ready,
   input wire        o_done,
   input wire        o_rd_we,
   input wire [31:0] o_rd_data,
   input wire        o_priv_fault,
   input wire        o_access_fault,
   input wire [31:0] o_msr,
   input wire        o_xlat_req,
   input wire        o_xlat_store,
   input wire        i_xlat_ack,
   input wire        i_xlat_fault,
   input wire        i_xlat_direct_store,
   input wire [31:0] i_xlat_pa,
   input wire        o_dc_inval_req,
   input wire        o_bus_kill_req,
   input wire [31:0] o_bus_kill_addr,
   input wire        o_sr_we,
   input wire [3:0]  o_sr_idx,
   input wire        o_xspr_req
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   wire       issue = i_valid && o_ready && i_instr[31:26] == `SSD_PRIMARY_OP;
   wire       take  = issue && !o_msr[`SSD_MSR_PROBLEM_BIT];
   wire [9:0] xo    = i_instr[10:1];
   wire [9:0] num   = {i_instr[15:11], i_instr[20:16]};
   reg  [3:0] rb_top_q;
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) rb_top_q <= 4'h0;
      else rb_top_q <= i_rb_val[31:28];
   end
   a_store_sem: assert property (o_xlat_store)
      else $error("invalidate not checked as store");
   a_priv_inval: assert property (issue && xo == `SSD_XO_DCBI && o_msr[14] |=> o_done && o_priv_fault && !o_xlat_req)
      else $error("user invalidate not refused");
   a_kill_pair: assert property ($rose(o_dc_inval_req) |-> $rose(o_bus_kill_req))
      else $error("invalidate without bus kill");
   a_kill_addr: assert property ($rose(o_bus_kill_req) |-> o_bus_kill_addr == $past(i_xlat_pa))
      else $error("kill address not translated");
   a_xlat_first: assert property ($rose(o_dc_inval_req) |-> $past(o_xlat_req) && $past(i_xlat_ack))
      else $error("cache acted before translation");
   a_fault_stop: assert property (o_xlat_req && i_xlat_ack && i_xlat_fault |=> o_done && o_access_fault && !o_bus_kill_req)
      else $error("protection fault not reported");
   a_dstore_noop: assert property (o_xlat_req && i_xlat_ack && !i_xlat_fault && i_xlat_direct_store
      |=> o_done && !o_dc_inval_req && !o_bus_kill_req ##1 !o_bus_kill_req)
      else $error("direct-store invalidate had effect");
   a_sr_indirect: assert property (take && xo == `SSD_XO_MTSRIN |=> o_sr_we && o_sr_idx == rb_top_q)
      else $error("indirect segment index wrong");
   a_msr_read: assert property (take && xo == `SSD_XO_MFMSR |=> o_done && o_rd_we && o_rd_data == o_msr)
      else $error("state register read wrong");
   a_spr_local: assert property (take && xo == `SSD_XO_MFSPR && (num[9:3] == 7'h77 || num == 10'h3f2 || num == 10'h3ff)
      |=> o_done && o_rd_we && !o_xspr_req)
      else $error("local register sent outside");
endmodule // ssd_chk
bind ssd_decode ssd_chk ssd_chk_inst (.*);

// File: bench/ssd_far_model.sv
// model of translation unit, data cache, system bus, segment and outer registers
// assumes requests hold until acknowledged, one core clock
`timescale 1ns/100ps
module ssd_far_model (
   // clock and reset
   input  wire        i_clk,
   input  wire        i_rst_n,
   // scenario controls
   input  wire        i_fault,
   input  wire        i_dstore,
   input  wire [1:0]  i_dly,
   // requests
   input  wire        i_xlat_req,
   input  wire [31:0] i_xlat_ea,
   input  wire        i_dc_req,
   input  wire        i_kill_req,
   input  wire        i_sr_we,
   input  wire        i_sr_rd_req,
   input  wire [3:0]  i_sr_idx,
   input  wire [31:0] i_sr_wdata,
   input  wire        i_xspr_req,
   input  wire [9:0]  i_xspr_num,
   // answers
   output reg         o_xlat_ack,
   output wire        o_xlat_fault,
   output wire        o_xlat_ds,
   output wire [31:0] o_xlat_pa,
   output reg         o_dc_ack,
   output reg         o_kill_ack,
   output wire [31:0] o_sr_rdata,
   output reg         o_xspr_ack,
   output wire [31:0] o_xspr_rdata
);
   reg [7:0]  c_x, c_d, c_k, c_s;
   reg [31:0] sr_q [0:15];
   // counts saturate so each request is acknowledged once
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         {c_x, c_d, c_k, c_s} <= 32'h0;
         {o_xlat_ack, o_dc_ack, o_kill_ack, o_xspr_ack} <= 4'h0;
      end else begin
         c_x <= !i_xlat_req ? 8'h0 : c_x + {7'h0, c_x != 8'hff};
         c_d <= !i_dc_req ? 8'h0 : c_d + {7'h0, c_d != 8'hff};
         c_k <= !i_kill_req ? 8'h0 : c_k + {7'h0, c_k != 8'hff};
         c_s <= !i_xspr_req ? 8'h0 : c_s + {7'h0, c_s != 8'hff};
         o_xlat_ack <= i_xlat_req && c_x == {6'h0, i_dly};
         o_dc_ack   <= i_dc_req && c_d == {6'h0, i_dly};
         o_kill_ack <= i_kill_req && c_k == {6'h0, i_dly} + 8'h1;
         o_xspr_ack <= i_xspr_req && c_s == {6'h0, i_dly};
      end
   end
   always @(posedge i_clk) begin
      if (i_sr_we) sr_q[i_sr_idx] <= i_sr_wdata;
   end
   // idle data lines carry a moving pattern, never the last value
   assign o_xlat_fault = o_xlat_ack & i_fault;
   assign o_xlat_ds    = o_xlat_ack & i_dstore;
   assign o_xlat_pa    = o_xlat_ack ? i_xlat_ea ^ 32'h40000000 : {4{c_x}};
   assign o_sr_rdata   = i_sr_rd_req ? sr_q[i_sr_idx] : {4{c_d ^ c_x}};
   assign o_xspr_rdata = o_xspr_ack ? {22'h0, i_xspr_num} ^ 32'h5a000000 : {4{c_s}};
endmodule // ssd_far_model

// File: bench/ssd_decode_test.sv
// self-checking bench for the supervisor decode block
// assumes the far side model answers translation, cache, bus and registers
`timescale 1ns/100ps
`include "ssd_defines.vh"
module ssd_decode_test;
   reg        i_clk, i_rst_n, i_valid, x_fault, x_dstore;
   reg [1:0]  x_dly;
   reg [31:0] i_instr, i_ra_val, i_rb_val, i_rs_val;
   wire       o_ready, o_done, o_rd_we, o_priv_fault, o_access_fault, o_illegal, o_xlat_req, o_xlat_store;
   wire       o_dc_inval_req, o_bus_kill_req, o_sr_we, o_sr_rd_req, o_xspr_req, o_xspr_write;
   wire       i_xlat_ack, i_xlat_fault, i_xlat_direct_store, i_dc_inval_ack, i_bus_kill_ack, i_xspr_ack;
   wire [31:0] o_rd_data, o_msr, o_xlat_ea, o_dc_inval_addr, o_bus_kill_addr, o_sr_wdata, o_xspr_wdata;
   wire [31:0] i_xlat_pa, i_sr_rdata, i_xspr_rdata;
   wire [3:0] o_sr_idx;
   wire [9:0] o_xspr_num;
   integer    num_errors = 0, cmp_count = 0, i;
   logic      done_seen, kill_seen, side_seen, dc_seen;
   logic [3:0] res;
   logic [31:0] rd, kill_addr, ea, dc_addr;
   logic [32:0] xw;
   logic [9:0] nums [0:9] = '{10'h3b8, 10'h3b9, 10'h3ba, 10'h3bb, 10'h3bc, 10'h3bd, 10'h3be, 10'h3bf, 10'h3f2, 10'h3ff};
   ssd_decode ssd_decode_inst (.*);
   ssd_far_model ssd_far_model_inst (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_fault(x_fault), .i_dstore(x_dstore),
      .i_dly(x_dly), .i_xlat_req(o_xlat_req), .i_xlat_ea(o_xlat_ea), .i_dc_req(o_dc_inval_req),
      .i_kill_req(o_bus_kill_req), .i_sr_we(o_sr_we), .i_sr_rd_req(o_sr_rd_req), .i_sr_idx(o_sr_idx),
      .i_sr_wdata(o_sr_wdata), .i_xspr_req(o_xspr_req), .i_xspr_num(o_xspr_num), .o_xlat_ack(i_xlat_ack),
      .o_xlat_fault(i_xlat_fault), .o_xlat_ds(i_xlat_direct_store), .o_xlat_pa(i_xlat_pa),
      .o_dc_ack(i_dc_inval_ack), .o_kill_ack(i_bus_kill_ack), .o_sr_rdata(i_sr_rdata),
      .o_xspr_ack(i_xspr_ack), .o_xspr_rdata(i_xspr_rdata));
   initial begin
      i_clk = 1'b0;
      forever #2 i_clk = ~i_clk;
   end
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function [31:0] op(input [9:0] xo, input [4:0] a, input [4:0] b);
      op = {6'h1f, 5'h03, a, b, xo, 1'b0};
   endfunction
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic do_reset;
      @(posedge i_clk);
      i_rst_n <= 1'b0;
      repeat (8) @(posedge i_clk);
      i_rst_n <= 1'b1;
   endtask
   // offer one instruction, collect what comes back until done
   task automatic issue(input [31:0] ins, input [31:0] a, input [31:0] b, input [31:0] s);
      @(posedge i_clk);
      {i_valid, i_instr, i_ra_val, i_rb_val, i_rs_val} <= {1'b1, ins, a, b, s};
      @(posedge i_clk);
      i_valid <= 1'b0;
      {done_seen, kill_seen, side_seen, dc_seen} = 4'h0;
      for (int n = 0; n < 64 && done_seen !== 1'b1; n++) begin
         @(negedge i_clk);
         if (o_bus_kill_req === 1'b1) {kill_seen, kill_addr} = {1'b1, o_bus_kill_addr};
         if (o_dc_inval_req === 1'b1) {dc_seen, dc_addr} = {1'b1, o_dc_inval_addr};
         if (o_xspr_req === 1'b1) xw = {o_xspr_write, o_xspr_wdata};
         if (o_xlat_req === 1'b1 || o_xspr_req === 1'b1) side_seen = 1'b1;
         if (o_done === 1'b1) {done_seen, res, rd} = {1'b1, o_rd_we, o_priv_fault, o_access_fault, o_illegal, o_rd_data};
      end
      chk("done", 1, done_seen);
   endtask
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_spr;
      for (i = 0; i < 10; i++) issue(op(`SSD_XO_MTSPR, nums[i][4:0], nums[i][9:5]), 0, 0, 32'h10000000 + i);
      for (i = 0; i < 10; i++) begin
         issue(op(`SSD_XO_MFSPR, nums[i][4:0], nums[i][9:5]), 0, 0, 0);
         chk("spr data", 32'h10000000 + i, rd);
         chk("spr local", 0, side_seen);
      end
      issue(op(`SSD_XO_MFSPR, 5'h10, 5'h08), 0, 0, 0);
      chk("spr outer", 32'h5a000110, rd);
      chk("xspr read", 0, xw[32]);
      issue(op(`SSD_XO_MTSPR, 5'h10, 5'h08), 0, 0, 32'h0badf00d);
      chk("xspr wdata", 32'h0badf00d, xw[31:0]);
      chk("xspr write", 1, xw[32]);
      chk("xspr no rd", 0, res[3]);
      $display("test spr done");
   endtask
   task automatic t_msr_seg;
      issue(op(`SSD_XO_MTMSR, 0, 0), 0, 0, 32'h00000030);
      issue(op(`SSD_XO_MFMSR, 0, 0), 0, 0, 0);
      chk("msr read", 32'h00000030, rd);
      issue(op(`SSD_XO_MTSR, 5'h05, 0), 0, 0, 32'ha5a50005);
      issue(op(`SSD_XO_MTSRIN, 0, 0), 0, 32'hc0000000, 32'h3c3c000c);
      issue(op(`SSD_XO_MFSRIN, 0, 0), 0, 32'h5fffffff, 0);
      chk("sr indirect", 32'ha5a50005, rd);
      issue(op(`SSD_XO_MFSR, 5'h0c, 0), 0, 0, 0);
      chk("sr direct", 32'h3c3c000c, rd);
      $display("test msr seg done");
   endtask
   task automatic t_inval;
      for (i = 0; i < 3; i++) begin
         {x_fault, x_dstore, x_dly} <= {i == 1, i == 2, 2'(i + 1)};
         ea = 32'h20000100 + i * 32;
         issue(op(`SSD_XO_DCBI, 5'h01, 5'h02), 32'h00000100 + i * 32, 32'h20000000, 0);
         chk("fault", i == 1, res[1]);
         chk("kill", i == 0, kill_seen);
         chk("cache", i == 0, dc_seen);
         if (i == 0) chk("kill addr", ea ^ 32'h40000000, kill_addr);
         if (i == 0) chk("cache addr", ea ^ 32'h40000000, dc_addr);
      end
      $display("test inval done");
   endtask
   task automatic t_priv;
      issue(op(`SSD_XO_MTMSR, 0, 0), 0, 0, 32'h00004000);
      issue(op(`SSD_XO_DCBI, 5'h01, 5'h02), 32'h100, 32'h200, 0);
      chk("user inval", 4'b0100, res);
      chk("user side", 0, side_seen | kill_seen);
      issue(op(`SSD_XO_MTSPR, 5'h18, 5'h1d), 0, 0, 32'h1);
      chk("user spr", 4'b0100, res);
      do_reset;
      @(negedge i_clk);
      chk("msr reset", 0, o_msr);
      issue(op(`SSD_XO_MFSPR, 5'h18, 5'h1d), 0, 0, 0);
      chk("spr reset", 0, rd);
      issue(op(10'h000, 0, 0), 0, 0, 0);
      chk("illegal", 4'b0001, res);
      $display("test priv done");
   endtask
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      {i_rst_n, i_valid, i_instr, i_ra_val, i_rb_val, i_rs_val} = 130'h0;
      {x_fault, x_dstore, x_dly} = 4'h0;
      do_reset;
      t_spr;
      t_msr_seg;
      t_inval;
      t_priv;
      conclude;
   end
   initial begin
      #20000;
      num_errors++;
      conclude;
   end
endmodule // ssd_decode_test
